// ### core/aesc_map.svh
// =====================================================================
`ifndef AESC_MAP_SVH
`define AESC_MAP_SVH

// =====================================================================
// register byte offsets (32-bit words)
`define AESC_OFS_CTRL    6'h00
`define AESC_OFS_STATUS  6'h04
`define AESC_OFS_MASK    6'h08
`define AESC_OFS_KEY     6'h10
`define AESC_OFS_STATE   6'h20
`define AESC_REGION_MASK 6'h30

// =====================================================================
// field positions
`define AESC_CTRL_START 0
`define AESC_CTRL_DEC   1
`define AESC_CTRL_AUTO  2
`define AESC_CTRL_XOR   3
`define AESC_STS_DONE   0
`define AESC_STS_BUSY   1

// =====================================================================
// reset values and timing
`define AESC_CTRL_RST   4'h0
`define AESC_MASK_RST   1'b0
`define AESC_LAT_CYC    375
`define AESC_LAT_MIN    24
`define AESC_LAT_MAX    511
`define AESC_RCON_FIRST 8'h01
`define AESC_RCON_LAST  8'h36

`endif

// ### core/aesc_pkg.sv
package aesc_pkg;

    // =================================================================
    // types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_KEXP = 2'b01,
        ST_CORE = 2'b10,
        ST_HOLD = 2'b11
    } aesc_phase_t;

    localparam logic [7:0] AESC_POLY  = 8'h1B;
    localparam logic [7:0] AESC_AFF   = 8'h63;
    localparam logic [7:0] AESC_IAFF  = 8'h05;

    // =================================================================
    // field arithmetic; sbox built from inversion to avoid 2 x 256 tables
    function automatic logic [7:0] aesc_xt(input logic [7:0] b);
        return {b[6:0], 1'b0} ^ (b[7] ? AESC_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] aesc_ixt(input logic [7:0] b);
        return b[0] ? (((b ^ AESC_POLY) >> 1) | 8'h80) : (b >> 1);
    endfunction

    function automatic logic [7:0] aesc_mul(input logic [7:0] x, input logic [7:0] y);
        logic [7:0] p;
        logic [7:0] a;
        p = 8'h00;
        a = x;
        for (int i = 0; i < 8; i++) begin
            if (y[i]) p = p ^ a;
            a = aesc_xt(a);
        end
        return p;
    endfunction

    // x^254, zero maps to zero
    function automatic logic [7:0] aesc_inv(input logic [7:0] x);
        logic [7:0] sq;
        logic [7:0] r;
        sq = x;
        r = 8'h01;
        for (int k = 1; k < 8; k++) begin
            sq = aesc_mul(sq, sq);
            r = aesc_mul(r, sq);
        end
        return r;
    endfunction

    function automatic logic [7:0] aesc_rotl(input logic [7:0] b, input int n);
        logic [15:0] d;
        d = {b, b} << n;
        return d[15:8];
    endfunction

    function automatic logic [7:0] aesc_sbox(input logic [7:0] x);
        logic [7:0] i;
        i = aesc_inv(x);
        return i ^ aesc_rotl(i, 1) ^ aesc_rotl(i, 2) ^ aesc_rotl(i, 3)
                 ^ aesc_rotl(i, 4) ^ AESC_AFF;
    endfunction

    function automatic logic [7:0] aesc_isbox(input logic [7:0] x);
        return aesc_inv(aesc_rotl(x, 1) ^ aesc_rotl(x, 3) ^ aesc_rotl(x, 6) ^ AESC_IAFF);
    endfunction

    function automatic logic [31:0] aesc_subw(input logic [31:0] w);
        return {aesc_sbox(w[31:24]), aesc_sbox(w[23:16]),
                aesc_sbox(w[15:8]), aesc_sbox(w[7:0])};
    endfunction

endpackage

// ### core/aesc_round.sv
`timescale 1ns/1ps
`default_nettype none

// one cipher round, forward or inverse; byte n sits at bits 127-8n
module aesc_round
    import aesc_pkg::*;
(
    input  wire logic [127:0] blk_in,
    input  wire logic [127:0] rkey,
    input  wire logic         dec,
    input  wire logic         mix,
    output logic      [127:0] blk_out
);

    always_comb begin
        logic [127:0] v;
        logic [7:0]   a [4];
        logic [7:0]   cf [4];
        logic [7:0]   acc;
        int           src;
        v = '0;
        acc = 8'h00;
        src = 0;
        for (int j = 0; j < 4; j++) begin
            a[j] = 8'h00;
        end
        cf[0] = dec ? 8'h0E : 8'h02;
        cf[1] = dec ? 8'h0B : 8'h03;
        cf[2] = dec ? 8'h0D : 8'h01;
        cf[3] = dec ? 8'h09 : 8'h01;
        // row shift folded into the byte fetch
        for (int n = 0; n < 16; n++) begin
            src = dec ? 4 * (((n / 4) - (n % 4) + 4) % 4) + (n % 4)
                      : 4 * (((n / 4) + (n % 4)) % 4) + (n % 4);
            v[127 - 8 * n -: 8] = dec ? aesc_isbox(blk_in[127 - 8 * src -: 8])
                                      : aesc_sbox(blk_in[127 - 8 * src -: 8]);
        end
        if (dec) v = v ^ rkey;
        if (mix) begin
            for (int c = 0; c < 4; c++) begin
                for (int j = 0; j < 4; j++) begin
                    a[j] = v[127 - 8 * (4 * c + j) -: 8];
                end
                for (int r = 0; r < 4; r++) begin
                    acc = 8'h00;
                    for (int j = 0; j < 4; j++) begin
                        acc = acc ^ aesc_mul(a[(r + j) % 4], cf[j]);
                    end
                    v[127 - 8 * (4 * c + r) -: 8] = acc;
                end
            end
        end
        if (!dec) v = v ^ rkey;
        blk_out = v;
    end

endmodule

`default_nettype wire

// ### core/aesc_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "aesc_map.svh"

module aesc_engine
    import aesc_pkg::*;
#(
    parameter int LATENCY = `AESC_LAT_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    output logic             dma_trig
);

    generate
        if (LATENCY < `AESC_LAT_MIN || LATENCY > `AESC_LAT_MAX) begin : g_bad_lat
            $error("LATENCY outside the range the sequencer can serve");
        end
    endgenerate

    // =================================================================
    // bus slave: every access answers one cycle after it is raised
    logic        ack_reg;
    logic        wr_go;
    logic        rd_go;
    logic        is_ctrl;
    logic        is_sts;
    logic        is_mask;
    logic        is_key;
    logic        is_st;
    logic [1:0]  widx;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_go           = avs_write & ack_reg;
    assign rd_go           = avs_read & ~ack_reg;
    assign widx            = avs_address[3:2];
    assign is_ctrl = avs_address == `AESC_OFS_CTRL;
    assign is_sts  = avs_address == `AESC_OFS_STATUS;
    assign is_mask = avs_address == `AESC_OFS_MASK;
    assign is_key  = ((avs_address & `AESC_REGION_MASK) == `AESC_OFS_KEY) && !avs_address[1]
                     && !avs_address[0];
    assign is_st   = ((avs_address & `AESC_REGION_MASK) == `AESC_OFS_STATE) && !avs_address[1]
                     && !avs_address[0];

    always_ff @(posedge mclk) begin
        if (rst) ack_reg <= 1'b0;
        else     ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    // =================================================================
    // control and mask
    logic        dec_reg;
    logic        auto_reg;
    logic        xor_reg;
    logic        mask_reg;
    logic        busy_reg;
    logic        auto_pend_reg;
    logic        start_go;
    logic        dec_now;

    always_ff @(posedge mclk) begin
        if (rst) begin
            {xor_reg, auto_reg, dec_reg} <= 3'(`AESC_CTRL_RST >> 1);
            mask_reg <= `AESC_MASK_RST;
        end else if (wr_go && avs_byteenable[0]) begin
            if (is_ctrl) begin
                // direction frozen while busy: the rounds read it live
                if (!busy_reg) dec_reg <= avs_writedata[`AESC_CTRL_DEC];
                auto_reg <= avs_writedata[`AESC_CTRL_AUTO];
                xor_reg  <= avs_writedata[`AESC_CTRL_XOR];
            end
            if (is_mask) mask_reg <= avs_writedata[`AESC_STS_DONE];
        end
    end

    // last byte lands this edge, so the auto start waits one cycle to see it
    always_ff @(posedge mclk) begin
        if (rst) auto_pend_reg <= 1'b0;
        else     auto_pend_reg <= wr_go && is_st && widx == 2'd3 && avs_byteenable[3]
                                  && auto_reg && !busy_reg;
    end

    assign start_go = !busy_reg && (auto_pend_reg || (wr_go && is_ctrl && avs_byteenable[0]
                      && avs_writedata[`AESC_CTRL_START]));

    // a start written together with a new direction must take that direction
    assign dec_now = (wr_go && is_ctrl && avs_byteenable[0] && !busy_reg)
                     ? avs_writedata[`AESC_CTRL_DEC] : dec_reg;

    // =================================================================
    // key and state memories; loads refused while busy
    logic [7:0]   key_mem [16];
    logic [7:0]   st_mem  [16];
    logic [127:0] key_vec;
    logic [127:0] st_vec;
    logic [127:0] blk_reg;
    logic         finish;

    always_comb begin
        for (int n = 0; n < 16; n++) begin
            key_vec[127 - 8 * n -: 8] = key_mem[n];
            st_vec[127 - 8 * n -: 8]  = st_mem[n];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int n = 0; n < 16; n++) key_mem[n] <= 8'h00;
        end else if (wr_go && is_key && !busy_reg) begin
            for (int l = 0; l < 4; l++) begin
                if (avs_byteenable[l]) key_mem[4 * widx + l] <= avs_writedata[8 * l +: 8];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int n = 0; n < 16; n++) st_mem[n] <= 8'h00;
        end else if (finish) begin
            for (int n = 0; n < 16; n++) st_mem[n] <= blk_reg[127 - 8 * n -: 8];
        end else if (wr_go && is_st && !busy_reg) begin
            for (int l = 0; l < 4; l++) begin
                if (avs_byteenable[l]) begin
                    st_mem[4 * widx + l] <= xor_reg
                        ? st_mem[4 * widx + l] ^ avs_writedata[8 * l +: 8]
                        : avs_writedata[8 * l +: 8];
                end
            end
        end
    end

    // =================================================================
    // sequencer: key walk on decrypt only, rounds, then hold out the fixed latency
    aesc_phase_t  phase_reg;
    logic [8:0]   cnt_reg;
    logic [3:0]   rnd_reg;
    logic [127:0] wkey_reg;
    logic [7:0]   rcon_reg;
    logic [127:0] key_fwd;
    logic [127:0] key_bwd;
    logic [127:0] rkey;
    logic [127:0] rnd_out;
    logic [31:0]  tw;
    logic [31:0]  p3;

    always_comb begin
        tw = aesc_subw({wkey_reg[23:0], wkey_reg[31:24]}) ^ {rcon_reg, 24'h000000};
        key_fwd[127:96] = wkey_reg[127:96] ^ tw;
        key_fwd[95:64]  = wkey_reg[95:64] ^ key_fwd[127:96];
        key_fwd[63:32]  = wkey_reg[63:32] ^ key_fwd[95:64];
        key_fwd[31:0]   = wkey_reg[31:0] ^ key_fwd[63:32];
        p3 = wkey_reg[31:0] ^ wkey_reg[63:32];
        key_bwd[31:0]   = p3;
        key_bwd[63:32]  = wkey_reg[63:32] ^ wkey_reg[95:64];
        key_bwd[95:64]  = wkey_reg[95:64] ^ wkey_reg[127:96];
        key_bwd[127:96] = wkey_reg[127:96] ^ aesc_subw({p3[23:0], p3[31:24]})
                          ^ {rcon_reg, 24'h000000};
        rkey = dec_reg ? key_bwd : key_fwd;
    end

    aesc_round u_round (
        .blk_in  (blk_reg),
        .rkey    (rkey),
        .dec     (dec_reg),
        .mix     (rnd_reg != 4'd10),
        .blk_out (rnd_out)
    );

    assign finish = busy_reg && cnt_reg == 9'(LATENCY - 1);

    always_ff @(posedge mclk) begin
        if (rst) cnt_reg <= 9'h000;
        else if (start_go) cnt_reg <= 9'h000;
        else if (busy_reg) cnt_reg <= cnt_reg + 9'h001;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
            rnd_reg   <= 4'h0;
            blk_reg   <= '0;
            wkey_reg  <= '0;
            rcon_reg  <= 8'h00;
        end else begin
            unique case (phase_reg)
                ST_IDLE: begin
                    if (start_go) begin
                        busy_reg  <= 1'b1;
                        rnd_reg   <= 4'h0;
                        blk_reg   <= st_vec;
                        wkey_reg  <= key_vec;
                        rcon_reg  <= `AESC_RCON_FIRST;
                        phase_reg <= dec_now ? ST_KEXP : ST_CORE;
                    end
                end
                // inverse cipher starts from the last round key
                ST_KEXP: begin
                    wkey_reg <= key_fwd;
                    rnd_reg  <= rnd_reg + 4'h1;
                    if (rnd_reg == 4'd9) begin
                        rnd_reg   <= 4'h0;
                        phase_reg <= ST_CORE;
                    end else begin
                        rcon_reg <= aesc_xt(rcon_reg);
                    end
                end
                ST_CORE: begin
                    rnd_reg <= rnd_reg + 4'h1;
                    if (rnd_reg == 4'd0) begin
                        blk_reg <= blk_reg ^ wkey_reg;
                    end else begin
                        blk_reg  <= rnd_out;
                        wkey_reg <= rkey;
                        rcon_reg <= dec_reg ? aesc_ixt(rcon_reg) : aesc_xt(rcon_reg);
                        if (rnd_reg == 4'd10) phase_reg <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (finish) begin
                        busy_reg  <= 1'b0;
                        phase_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // =================================================================
    // status, interrupt, dma; completion beats a same-cycle read clear
    logic done_reg;

    always_ff @(posedge mclk) begin
        if (rst) done_reg <= 1'b0;
        else if (finish) done_reg <= 1'b1;
        else if (start_go) done_reg <= 1'b0;
        else if (rd_go && is_sts) done_reg <= 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (rst) dma_trig <= 1'b0;
        else     dma_trig <= finish;
    end

    assign irq = done_reg & mask_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            avs_readdata <= 32'h0000_0000;
            if (is_ctrl) avs_readdata[3:1] <= {xor_reg, auto_reg, dec_reg};
            if (is_sts) avs_readdata[1:0] <= {busy_reg, done_reg};
            if (is_mask) avs_readdata[0] <= mask_reg;
            if (is_key) avs_readdata <= {key_mem[4 * widx + 3], key_mem[4 * widx + 2],
                                         key_mem[4 * widx + 1], key_mem[4 * widx]};
            if (is_st) avs_readdata <= {st_mem[4 * widx + 3], st_mem[4 * widx + 2],
                                        st_mem[4 * widx + 1], st_mem[4 * widx]};
        end
    end

    // =================================================================
    // checks
    logic [9:0] busy_len;

    always_ff @(posedge mclk) begin
        if (rst || start_go) busy_len <= 10'h000;
        else if (busy_reg) busy_len <= busy_len + 10'h001;
    end

    sequence s_auto_fill;
        wr_go && is_st && widx == 2'd3 && avs_byteenable[3] && auto_reg && !busy_reg;
    endsequence

    a_latency_exact: assert property (@(posedge mclk) disable iff (rst)
        $fell(busy_reg) |-> busy_len == 10'(LATENCY))
        else $error("operation did not take the set latency");
    a_dma_on_done: assert property (@(posedge mclk) disable iff (rst)
        $fell(busy_reg) |-> dma_trig ##1 !dma_trig)
        else $error("dma trigger missing or too long");
    a_irq_when_enabled: assert property (@(posedge mclk) disable iff (rst)
        $fell(busy_reg) |-> irq == mask_reg)
        else $error("interrupt does not follow mask at completion");
    a_done_flag_held: assert property (@(posedge mclk) disable iff (rst)
        $fell(busy_reg) |-> done_reg ##1 (done_reg || $past(rd_go && is_sts) || $past(start_go)))
        else $error("done flag lost without clear");
    a_auto_start_go: assert property (@(posedge mclk) disable iff (rst)
        s_auto_fill |-> ##2 busy_reg)
        else $error("auto start did not begin");
    a_xor_load_mix: assert property (@(posedge mclk) disable iff (rst)
        (wr_go && is_st && widx == 2'd0 && avs_byteenable == 4'hF && xor_reg && !busy_reg)
        |=> {st_mem[3], st_mem[2], st_mem[1], st_mem[0]}
            == ($past({st_mem[3], st_mem[2], st_mem[1], st_mem[0]}) ^ $past(avs_writedata)))
        else $error("xor load did not combine with old content");
    a_round_key_walk: assert property (@(posedge mclk) disable iff (rst)
        (phase_reg == ST_CORE && rnd_reg == 4'd0)
        |-> rcon_reg == (dec_reg ? `AESC_RCON_LAST : `AESC_RCON_FIRST))
        else $error("round constant wrong at first round");

endmodule

`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "aesc_map.svh"

module tb;
    import aesc_pkg::*;

    // =====================================================================
    // short latency keeps the run brief; every expected cycle count below follows it, the bus and dma timeouts do not
    localparam int LAT = 30;
    localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
    localparam logic [127:0] PT  = 128'h00112233445566778899AABBCCDDEEFF;
    localparam logic [127:0] CT  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;

    logic        mclk;
    logic        rst;
    logic [5:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic        dma_trig;
    int          error_cnt;
    int          n_checks;
    int          cyc;
    int          t0;
    logic [31:0] rd;

    aesc_engine #(.LATENCY(LAT)) DUT (
        .mclk            (mclk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .irq             (irq),
        .dma_trig        (dma_trig)
    );

    always #5 mclk = ~mclk;

    // edge count, read only at falling edges so it is settled
    always @(posedge mclk) cyc = cyc + 1;

    // =====================================================================
    // helpers
    task automatic summarize();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // byte n of a block sits in word n/4, lane n%4
    function automatic logic [31:0] word_of(input logic [127:0] b, input int i);
        return {b[127-8*(4*i+3) -: 8], b[127-8*(4*i+2) -: 8],
                b[127-8*(4*i+1) -: 8], b[127-8*(4*i) -: 8]};
    endfunction

    // one access; waitrequest is sampled mid-cycle, the request drops after the taking edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        logic w;
        int   n;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        n = 0;
        do begin
            @(negedge mclk);
            w = avs_waitrequest;
            q = avs_readdata;
            n++;
            if (n > 20) begin
                error_cnt++;
                summarize();
            end
            @(posedge mclk);
        end while (w !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, rd);
        check(rd, exp);
    endtask

    task automatic load(input logic [5:0] base, input logic [127:0] b);
        for (int i = 0; i < 4; i++) wr(base + 6'(4 * i), word_of(b, i));
    endtask

    task automatic state_chk(input logic [127:0] b);
        for (int i = 0; i < 4; i++) rd_chk(`AESC_OFS_STATE + 6'(4 * i), word_of(b, i));
    endtask

    task automatic mark_t0();
        @(negedge mclk);
        t0 = cyc;
    endtask

    task automatic wait_dma(input int exp_cyc, input logic exp_irq);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
            if (n > 1000) begin
                error_cnt++;
                summarize();
            end
        end while (dma_trig !== 1'b1);
        check(32'(cyc - t0), 32'(exp_cyc));
        check({31'h0, irq}, {31'h0, exp_irq});
        @(negedge mclk);
        check({31'h0, dma_trig}, 32'h0000_0000);
    endtask

    // =====================================================================
    // scenarios
    task automatic t_reset_and_map();
        rd_chk(`AESC_OFS_CTRL, 32'h0000_0000);
        rd_chk(`AESC_OFS_STATUS, 32'h0000_0000);
        rd_chk(`AESC_OFS_MASK, 32'h0000_0000);
        wr(6'h34, 32'hFFFF_FFFF);
        rd_chk(6'h34, 32'h0000_0000);
        wr(`AESC_OFS_CTRL, 32'h0000_000E);
        rd_chk(`AESC_OFS_CTRL, 32'h0000_000E);
        wr(`AESC_OFS_CTRL, 32'h0000_0000);
    endtask

    task automatic t_encrypt();
        load(`AESC_OFS_KEY, KEY);
        load(`AESC_OFS_STATE, PT);
        wr(`AESC_OFS_MASK, 32'h0000_0001);
        wr(`AESC_OFS_CTRL, 32'h0000_0001);
        mark_t0();
        wait_dma(LAT, 1'b1);
        state_chk(CT);
        rd_chk(`AESC_OFS_STATUS, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0000);
        rd_chk(`AESC_OFS_STATUS, 32'h0000_0000);
    endtask

    // key write and second start during busy must both be dropped
    task automatic t_decrypt_busy();
        wr(`AESC_OFS_CTRL, 32'h0000_0003);
        mark_t0();
        rd_chk(`AESC_OFS_STATUS, 32'h0000_0002);
        wr(`AESC_OFS_KEY, 32'hFFFF_FFFF);
        wr(`AESC_OFS_CTRL, 32'h0000_0003);
        wait_dma(LAT, 1'b1);
        state_chk(PT);
        rd_chk(`AESC_OFS_KEY, word_of(KEY, 0));
    endtask

    // done left set, so the auto start must clear it
    task automatic t_auto_start();
        wr(`AESC_OFS_MASK, 32'h0000_0000);
        wr(`AESC_OFS_CTRL, 32'h0000_0004);
        load(`AESC_OFS_STATE, PT);
        mark_t0();
        rd_chk(`AESC_OFS_STATUS, 32'h0000_0002);
        wait_dma(LAT + 1, 1'b0);
        state_chk(CT);
        rd_chk(`AESC_OFS_STATUS, 32'h0000_0001);
    endtask

    task automatic t_xor_load();
        wr(`AESC_OFS_CTRL, 32'h0000_0008);
        load(`AESC_OFS_STATE, CT);
        state_chk(128'h0);
        load(`AESC_OFS_STATE, PT);
        state_chk(PT);
        wr(`AESC_OFS_CTRL, 32'h0000_0009);
        mark_t0();
        wait_dma(LAT, 1'b0);
        state_chk(CT);
    endtask

    // =====================================================================
    // main sequence
    initial begin
        mclk           = 1'b0;
        rst            = 1'b1;
        avs_address    = 6'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hF;
        error_cnt      = 0;
        n_checks       = 0;
        cyc            = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset_and_map();
        t_encrypt();
        t_decrypt_busy();
        t_auto_start();
        t_xor_load();
        summarize();
    end

endmodule

`default_nettype wire
